// ### hdl/isr_pkg.sv
// Constants and types for the instrument status reporting block
//
// Contract
// - Nonwaiting completion query answers 1 when idle, 0 while operations pend.
// - Active transient or ramped soft start counts as pending operation.
// - Power-on clear setting decides whether enable masks clear at power-on.
// - Reset command restores defaults, manual mode, clears transient list.
// - Service enable write loads 8-bit mask, kept across power loss only while power-on clear is 0.
// - Reading service enable returns value then clears it.
// - Status byte query returns value then resets status byte.
// - Wait command holds later commands until operations complete.
// - Clear-status clears status byte and standard event register.
// - Status bits 7,3,1,0: operation, questionable, busy mode, fault.
// - Status bits 5,4,2: event summary, message available, error queue.
// - Bit 6 ORs other bits for query; serial poll shows request.
// - Service enable bits unmask status bits; enable bit 6 ignored.
// - Status, service enable, event and event enable are 8 bits.
// - Reading standard event register returns contents then clears it.
// - Event summary sets when any enabled standard event is true.
// - Event bits: 7 power, 6 local, 5..2 errors, 0 complete.
// - Group condition rising sets its latched event bit.
// - Group enable bits pass event bits to group summary.
// - Group registers are 16 bits; reading group event clears it.
// - Questionable enabled events OR into status byte bit 3.
// - Operation complete command sets event bit 0 when idle.
// - Event enable survives reset command, clears on power cycle only while power-on clear is 1.
package isr_pkg;
   localparam int SB_W  = 8;
   localparam int GRP_W = 16;
   // Status byte positions
   localparam int SB_FAULT = 0;
   localparam int SB_BUSY  = 1;
   localparam int SB_EEQ   = 2;
   localparam int SB_QUES  = 3;
   localparam int SB_MAV   = 4;
   localparam int SB_ESB   = 5;
   localparam int SB_MSS   = 6;
   localparam int SB_OPER  = 7;
   // Standard event positions
   localparam int EV_OPC = 0;
   localparam int EV_QYE = 2;
   localparam int EV_DDE = 3;
   localparam int EV_EXE = 4;
   localparam int EV_CME = 5;
   localparam int EV_URQ = 6;
   localparam int EV_PON = 7;
   localparam logic [7:0]  EV_USED_MASK = 8'hfd;
   localparam logic [15:0] QUES_USED_MASK = 16'h61ff;
   localparam logic [7:0]  ZERO8  = 8'h00;
   localparam logic [15:0] ZERO16 = 16'h0000;
   // Command codes
   typedef enum logic [3:0] {
      ISR_NOP, ISR_CLS, ISR_ESE_WR, ISR_ESE_RD, ISR_ESR_RD, ISR_OPC,
      ISR_OPC_Q, ISR_PSC_WR, ISR_PSC_RD, ISR_RST, ISR_SRE_WR, ISR_SRE_RD,
      ISR_STB_RD, ISR_WAI, ISR_GRP_RD, ISR_GRP_WR
   } isr_cmd_t;
   // Group register selectors
   localparam logic [2:0] G_OPER_COND = 3'h0;
   localparam logic [2:0] G_OPER_EVT  = 3'h1;
   localparam logic [2:0] G_OPER_ENA  = 3'h2;
   localparam logic [2:0] G_QUES_COND = 3'h3;
   localparam logic [2:0] G_QUES_EVT  = 3'h4;
   localparam logic [2:0] G_QUES_ENA  = 3'h5;
   // Reset cycle time
   localparam int RST_TIME_MS = 20000;
   localparam int CLK_MHZ     = 250;
endpackage : isr_pkg

// ### hdl/isr_sgroup.sv
// One 16-bit condition, event and enable group with summary
module isr_sgroup
   import isr_pkg::*;
#(
   parameter int W = GRP_W
)(
   input  wire logic         clock,
   input  wire logic         rstn,
   input  wire logic [W-1:0] cond,
   input  wire logic         ena_wr,
   input  wire logic [W-1:0] ena_data,
   input  wire logic         evt_rd,
   input  wire logic         clr,
   output logic      [W-1:0] cond_q,
   output logic      [W-1:0] evt,
   output logic      [W-1:0] ena,
   output logic              summary
);
   logic [W-1:0] next_cond_q;
   logic [W-1:0] next_evt;
   logic [W-1:0] next_ena;
   always_comb
   begin
      next_cond_q = cond;
      next_evt    = evt;
      if (evt_rd || clr)
      begin
         next_evt = '0;
      end
      next_evt = next_evt | (cond & ~cond_q);
      next_ena = ena_wr ? ena_data : ena;
   end
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         cond_q <= '0;
         evt    <= '0;
         ena    <= '0;
      end
      else
      begin
         cond_q <= next_cond_q;
         evt    <= next_evt;
         ena    <= next_ena;
      end
   end
   assign summary = |(evt & ena);
endmodule : isr_sgroup

// ### hdl/isr_status.sv
// Status byte, standard event and SCPI group reporting block
module isr_status
   import isr_pkg::*;
#(
   parameter longint RST_CYCLES = longint'(RST_TIME_MS) * 1000 * CLK_MHZ
)(
   input  wire logic              clock,
   input  wire logic              rstn,
   input  wire logic              power_on,
   input  wire logic              cmd_valid,
   output logic                   cmd_ready,
   input  wire isr_cmd_t          cmd_code,
   input  wire logic [GRP_W-1:0]  cmd_data,
   input  wire logic [2:0]        cmd_sel,
   output logic                   rsp_valid,
   output logic      [GRP_W-1:0]  rsp_data,
   input  wire logic              serial_poll,
   input  wire logic              fault,
   input  wire logic              not_vi_mode,
   input  wire logic              msg_available,
   input  wire logic              error_queue_pending,
   input  wire logic [GRP_W-1:0]  oper_cond,
   input  wire logic [GRP_W-1:0]  ques_cond,
   input  wire logic              transient_active,
   input  wire logic              soft_start_active,
   input  wire logic [7:0]        event_set,
   output logic                   mode_manual,
   output logic                   transient_clear,
   output logic                   reset_busy,
   output logic                   service_request
);
   // Reset cycle counter width
   localparam int CNT_W = $clog2(RST_CYCLES + 1);
   typedef enum logic [1:0] {ISR_IDLE, ISR_WAIT, ISR_OPCW, ISR_RESET}
      isr_state_t;
   isr_state_t        state, next_state;
   logic [SB_W-1:0]   sre, next_sre;
   logic [SB_W-1:0]   ese, next_ese;
   logic [SB_W-1:0]   standard_event_flags, next_esr;
   logic [SB_W-1:0]   stb_clr, next_stb_clr;
   logic              psc, next_psc;
   logic              rqs, next_rqs;
   logic              mode_manual_q, next_mode_manual;
   logic              tclr, next_tclr;
   logic              rvalid, next_rvalid;
   logic [GRP_W-1:0]  rdata, next_rdata;
   logic [CNT_W-1:0]  rcnt, next_rcnt;
   logic              pending;
   logic              accept;
   logic              cls;
   logic              oper_rd, ques_rd, oper_wr, ques_wr;
   logic [GRP_W-1:0]  oper_cq, oper_ev, oper_en;
   logic [GRP_W-1:0]  ques_cq, ques_ev, ques_en;
   logic              oper_sum, ques_sum;
   logic [SB_W-1:0]   stb;
   logic [SB_W-1:0]   stb_raw;

   assign pending = transient_active | soft_start_active;
   assign cmd_ready = (state == ISR_IDLE);
   assign accept    = cmd_valid & cmd_ready;
   assign cls       = accept && cmd_code == ISR_CLS;
   assign oper_rd   = accept && cmd_code == ISR_GRP_RD
                      && cmd_sel == G_OPER_EVT;
   assign ques_rd   = accept && cmd_code == ISR_GRP_RD
                      && cmd_sel == G_QUES_EVT;
   assign oper_wr   = accept && cmd_code == ISR_GRP_WR
                      && cmd_sel == G_OPER_ENA;
   assign ques_wr   = accept && cmd_code == ISR_GRP_WR
                      && cmd_sel == G_QUES_ENA;

   isr_sgroup #(.W(GRP_W)) u_oper (
      .clock    (clock),
      .rstn     (rstn),
      .cond     (oper_cond),
      .ena_wr   (oper_wr),
      .ena_data (cmd_data),
      .evt_rd   (oper_rd),
      .clr      (cls),
      .cond_q   (oper_cq),
      .evt      (oper_ev),
      .ena      (oper_en),
      .summary  (oper_sum)
   );
   isr_sgroup #(.W(GRP_W)) u_ques (
      .clock    (clock),
      .rstn     (rstn),
      .cond     (ques_cond & QUES_USED_MASK),
      .ena_wr   (ques_wr),
      .ena_data (cmd_data),
      .evt_rd   (ques_rd),
      .clr      (cls),
      .cond_q   (ques_cq),
      .evt      (ques_ev),
      .ena      (ques_en),
      .summary  (ques_sum)
   );

   always_comb
   begin
      stb_raw = ZERO8;
      stb_raw[SB_OPER]  = oper_sum;
      stb_raw[SB_QUES]  = ques_sum;
      stb_raw[SB_BUSY]  = not_vi_mode;
      stb_raw[SB_FAULT] = fault;
      stb_raw[SB_ESB]   = |(standard_event_flags & ese);
      stb_raw[SB_MAV]   = msg_available;
      stb_raw[SB_EEQ]   = error_queue_pending;
      // query reset masks bits until they re-rise
      stb = stb_raw & ~stb_clr;
      stb[SB_MSS] = |stb;
   end

   always_comb
   begin
      next_state       = state;
      next_sre         = sre;
      next_ese         = ese;
      next_esr         = standard_event_flags;
      next_psc         = psc;
      next_mode_manual = mode_manual_q;
      next_tclr        = 1'b0;
      next_rvalid      = 1'b0;
      next_rdata       = rdata;
      next_rcnt        = rcnt;
      next_stb_clr     = stb_clr & stb_raw;
      next_rqs = rqs | (|(stb & sre & ~(8'h01 << SB_MSS)));
      if (serial_poll)
      begin
         next_rdata  = {ZERO8, stb[7:7], rqs, stb[5:0]};
         next_rvalid = 1'b1;
         next_rqs    = 1'b0;
      end
      if (accept)
      begin
         case (cmd_code)
            ISR_CLS:
            begin
               next_esr     = ZERO8;
               next_stb_clr = stb_raw;
               next_rqs     = 1'b0;
            end
            ISR_ESE_WR: next_ese = cmd_data[SB_W-1:0];
            ISR_ESE_RD:
            begin
               next_rdata  = {ZERO8, ese};
               next_rvalid = 1'b1;
            end
            ISR_ESR_RD:
            begin
               next_rdata  = {ZERO8, standard_event_flags};
               next_rvalid = 1'b1;
               next_esr    = ZERO8;
            end
            ISR_OPC:
            begin
               if (pending) next_state = ISR_OPCW;
               else next_esr[EV_OPC] = 1'b1;
            end
            ISR_OPC_Q:
            begin
               next_rdata  = {15'h0000, ~pending};
               next_rvalid = 1'b1;
            end
            ISR_PSC_WR: next_psc = cmd_data[0];
            ISR_PSC_RD:
            begin
               next_rdata  = {15'h0000, psc};
               next_rvalid = 1'b1;
            end
            ISR_RST:
            begin
               next_mode_manual = 1'b1;
               next_tclr        = 1'b1;
               next_state       = ISR_RESET;
               next_rcnt        = '0;
            end
            ISR_SRE_WR:
               next_sre = cmd_data[SB_W-1:0];
            ISR_SRE_RD:
            begin
               next_rdata  = {ZERO8, sre};
               next_rvalid = 1'b1;
               next_sre    = ZERO8;
            end
            ISR_STB_RD:
            begin
               next_rdata   = {ZERO8, stb};
               next_rvalid  = 1'b1;
               next_stb_clr = stb_raw;
            end
            ISR_WAI:
               if (pending) next_state = ISR_WAIT;
            ISR_GRP_RD:
            begin
               next_rvalid = 1'b1;
               case (cmd_sel)
                  G_OPER_COND: next_rdata = oper_cq;
                  G_OPER_EVT:  next_rdata = oper_ev;
                  G_OPER_ENA:  next_rdata = oper_en;
                  G_QUES_COND: next_rdata = ques_cq;
                  G_QUES_EVT:  next_rdata = ques_ev;
                  G_QUES_ENA:  next_rdata = ques_en;
                  default:     next_rdata = ZERO16;
               endcase
            end
            default: ;
         endcase
      end
      case (state)
         ISR_WAIT: if (!pending) next_state = ISR_IDLE;
         ISR_OPCW:
            if (!pending)
            begin
               next_esr[EV_OPC] = 1'b1;
               next_state       = ISR_IDLE;
            end
         ISR_RESET:
         begin
            next_rcnt = rcnt + CNT_W'(1);
            if (rcnt >= CNT_W'(RST_CYCLES - 1)) next_state = ISR_IDLE;
         end
         default: ;
      endcase
      next_esr = next_esr | (event_set & EV_USED_MASK);
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         state         <= ISR_IDLE;
         sre           <= ZERO8;
         ese           <= ZERO8;
         standard_event_flags           <= ZERO8;
         stb_clr       <= ZERO8;
         psc           <= 1'b1;
         rqs           <= 1'b0;
         mode_manual_q <= 1'b1;
         tclr          <= 1'b0;
         rvalid        <= 1'b0;
         rdata         <= ZERO16;
         rcnt          <= '0;
      end
      else if (power_on)
      begin
         state   <= ISR_IDLE;
         sre     <= psc ? ZERO8 : sre;
         ese     <= psc ? ZERO8 : ese;
         standard_event_flags     <= 8'h01 << EV_PON;
         stb_clr <= ZERO8;
         rqs     <= 1'b0;
         rvalid  <= 1'b0;
      end
      else
      begin
         state         <= next_state;
         sre           <= next_sre;
         ese           <= next_ese;
         standard_event_flags           <= next_esr;
         stb_clr       <= next_stb_clr;
         psc           <= next_psc;
         rqs           <= next_rqs;
         mode_manual_q <= next_mode_manual;
         tclr          <= next_tclr;
         rvalid        <= next_rvalid;
         rdata         <= next_rdata;
         rcnt          <= next_rcnt;
      end
   end

   assign mode_manual     = mode_manual_q;
   assign transient_clear = tclr;
   assign reset_busy      = (state == ISR_RESET);
   assign rsp_valid       = rvalid;
   assign rsp_data        = rdata;
   assign service_request = stb[SB_MSS];
endmodule : isr_status

// ### dv/isr_status_monitor.sv
// Assertion checker on the status reporting block ports
module isr_status_monitor
   import isr_pkg::*;
#(
   parameter longint RST_CYCLES = longint'(RST_TIME_MS) * 1000 * CLK_MHZ
)(
   input  wire logic             clock,
   input  wire logic             rstn,
   input  wire logic             power_on,
   input  wire logic             cmd_valid,
   input  wire logic             cmd_ready,
   input  wire isr_cmd_t         cmd_code,
   input  wire logic [GRP_W-1:0] cmd_data,
   input  wire logic [GRP_W-1:0] rsp_data,
   input  wire logic [GRP_W-1:0] oper_cond,
   input  wire logic [GRP_W-1:0] ques_cond,
   input  wire logic [2:0]       cmd_sel,
   input  wire logic             rsp_valid,
   input  wire logic             serial_poll,
   input  wire logic             fault,
   input  wire logic             not_vi_mode,
   input  wire logic             msg_available,
   input  wire logic             error_queue_pending,
   input  wire logic             transient_active,
   input  wire logic             soft_start_active,
   input  wire logic             mode_manual,
   input  wire logic             transient_clear,
   input  wire logic             reset_busy,
   input  wire logic             service_request,
   input  wire logic [7:0]       event_set
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        tk;
   logic        pnd;
   logic [63:0] busy_cnt;
   logic [63:0] next_busy_cnt;
   assign tk = cmd_valid && cmd_ready;
   assign pnd = transient_active || soft_start_active;
   always_comb next_busy_cnt = reset_busy ? busy_cnt + 64'h1 : 64'h0;
   always_ff @(posedge clock or negedge rstn)
      if (!rstn) busy_cnt <= 64'h0;
      else busy_cnt <= next_busy_cnt;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   opc_idle_a: assert property (
      tk && cmd_code == ISR_OPC_Q && !pnd && !$past(pnd)
      |=> rsp_valid && rsp_data == 16'h0001)
      else $error("idle completion answer wrong");
   opc_busy_a: assert property (
      tk && cmd_code == ISR_OPC_Q && pnd && $past(pnd)
      |=> rsp_valid && rsp_data == 16'h0000)
      else $error("pending completion answer wrong");
   wai_hold_a: assert property (
      tk && cmd_code == ISR_WAI && pnd && $past(pnd) |=> !cmd_ready)
      else $error("wait did not hold commands");
   ready_back_a: assert property (
      not ((!reset_busy && !pnd && !cmd_ready) [*4]))
      else $error("commands held with nothing pending");
   rst_len_a: assert property (
      busy_cnt <= 64'(RST_CYCLES))
      else $error("reset cycle too long");
   rst_exact_a: assert property (
      $fell(reset_busy) && !$past(power_on) |-> busy_cnt == 64'(RST_CYCLES))
      else $error("reset cycle length wrong");
   tlist_clr_a: assert property (
      tk && cmd_code == ISR_RST
      |-> ##[1:40] transient_clear && mode_manual)
      else $error("reset command left list or mode");
   rsp_cause_a: assert property (
      rsp_valid |-> $past(tk || serial_poll))
      else $error("answer without request");
   byte_wide_a: assert property (
      tk && cmd_code inside {ISR_SRE_RD, ISR_ESE_RD, ISR_ESR_RD, ISR_STB_RD}
      |=> rsp_data[15:8] == 8'h00)
      else $error("byte register wider than 8 bits");
   cond_read_a: assert property (
      tk && cmd_code == ISR_GRP_RD && cmd_sel == G_QUES_COND
      && ques_cond == $past(ques_cond)
      && $past(ques_cond) == $past(ques_cond, 2)
      |=> rsp_data == ($past(ques_cond) & QUES_USED_MASK))
      else $error("questionable condition readback wrong");
   cover property (tk && cmd_code == ISR_WAI && pnd);
   cover property (tk && cmd_code == ISR_RST);
   cover property (tk && cmd_code == ISR_GRP_RD);
   cover property (serial_poll && service_request);
endmodule : isr_status_monitor

bind isr_status isr_status_monitor #(.RST_CYCLES(RST_CYCLES)) mon (
   .clock, .rstn, .power_on, .cmd_valid, .cmd_ready, .cmd_code, .cmd_data,
   .cmd_sel, .rsp_valid, .rsp_data, .serial_poll, .fault, .not_vi_mode,
   .msg_available, .error_queue_pending, .oper_cond, .ques_cond,
   .transient_active, .soft_start_active, .event_set, .mode_manual,
   .transient_clear, .reset_busy, .service_request
);

// ### dv/isr_host.sv
// Host controller model issuing status commands
module isr_host
   import isr_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              cmd_ready,
   input  wire logic              rsp_valid,
   input  wire logic [GRP_W-1:0]  rsp_data,
   output logic                   cmd_valid,
   output isr_cmd_t               cmd_code,
   output logic      [GRP_W-1:0]  cmd_data,
   output logic      [2:0]        cmd_sel
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      cmd_valid = 1'b0;
      cmd_code = ISR_NOP;
      cmd_data = 16'h0000;
      cmd_sel = 3'h0;
   end
   task automatic xfer(input isr_cmd_t c, input logic [GRP_W-1:0] d,
                       input logic [2:0] s, output logic [GRP_W-1:0] r);
      r = 'x;
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_data <= d;
      cmd_sel <= s;
      do @(posedge clock); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      cmd_data <= ~d;
      cmd_sel <= ~s;
      repeat (3)
      begin
         @(posedge clock);
         if (rsp_valid === 1'b1) r = rsp_data;
      end
   endtask : xfer
endmodule : isr_host

// ### dv/isr_status_tb.sv
// Self-checking bench for the status reporting block
module isr_status_tb
   import isr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0, rstn = 1'b0, power_on = 1'b0, serial_poll = 1'b0;
   logic fault = 1'b0, not_vi_mode = 1'b0, msg_available = 1'b0;
   logic error_queue_pending = 1'b0, transient_active = 1'b0;
   logic soft_start_active = 1'b0;
   logic [GRP_W-1:0] oper_cond = '0, ques_cond = '0, cmd_data, rsp_data;
   logic [7:0] event_set = '0;
   logic cmd_valid, cmd_ready, rsp_valid, mode_manual, transient_clear;
   logic reset_busy, service_request;
   isr_cmd_t cmd_code;
   logic [2:0] cmd_sel;
   logic [31:0] seed = 32'h390358d3;
   int fail_count = 0, check_count = 0, cyc = 0, i;
   logic [15:0] v, c, en, r;
   always #2 clock = ~clock;
   isr_status #(.RST_CYCLES(8)) dut (
      .clock, .rstn, .power_on, .cmd_valid, .cmd_ready, .cmd_code, .cmd_data,
      .cmd_sel, .rsp_valid, .rsp_data, .serial_poll, .fault, .not_vi_mode,
      .msg_available, .error_queue_pending, .oper_cond, .ques_cond,
      .transient_active, .soft_start_active, .event_set, .mode_manual,
      .transient_clear, .reset_busy, .service_request);
   isr_host host (.clock, .cmd_ready, .rsp_valid, .rsp_data, .cmd_valid,
      .cmd_code, .cmd_data, .cmd_sel);
   function automatic logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction : rnd
   function automatic logic [15:0] stb_exp(input logic [7:0] b);
      return {8'h00, b[7], |{b[7], b[5:0]}, b[5:0]};
   endfunction : stb_exp
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic qry(input isr_cmd_t q, input logic [2:0] s,
                      input logic [15:0] e);
      logic [15:0] got;
      host.xfer(q, 16'h0000, s, got);
      chk(got, e);
   endtask : qry
   task automatic cmd(input isr_cmd_t q, input logic [15:0] d);
      host.xfer(q, d, 3'h0, r);
   endtask : cmd
   task automatic poll(input logic [15:0] e);
      serial_poll <= 1'b1;
      @(posedge clock);
      serial_poll <= 1'b0;
      @(posedge clock);
      chk((rsp_valid === 1'b1) ? rsp_data : 16'hffff, e);
   endtask : poll
   task automatic strobe(input logic [7:0] e, input logic p);
      @(posedge clock);
      event_set <= e;
      power_on <= p;
      @(posedge clock);
      event_set <= 8'h00;
      power_on <= 1'b0;
   endtask : strobe
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fail_count++;
         tally_and_finish();
      end
   end
   initial
   begin
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      qry(ISR_SRE_RD, 3'h0, 16'h0000);
      qry(ISR_ESE_RD, 3'h0, 16'h0000);
      qry(ISR_PSC_RD, 3'h0, 16'h0001);
      chk({15'h0, mode_manual}, 16'h0001);
      $display("test reset done");
      for (i = 0; i < 6; i++)
      begin
         v = (i == 0) ? 16'h00ff : (i == 1) ? 16'h0000 : rnd() & 16'h00ff;
         host.xfer(ISR_SRE_WR, v, 3'h0, r);
         qry(ISR_SRE_RD, 3'h0, v);
         qry(ISR_SRE_RD, 3'h0, 16'h0000);
      end
      $display("test service enable done");
      v = rnd() | 16'h0001;
      {msg_available, error_queue_pending, not_vi_mode, fault} <= v[3:0];
      repeat (3) @(posedge clock);
      chk({15'h0, service_request}, 16'h0001);
      qry(ISR_STB_RD, 3'h0, stb_exp({3'h0, v[3], 1'b0, v[2:0]}));
      qry(ISR_STB_RD, 3'h0, 16'h0000);
      chk({15'h0, service_request}, 16'h0000);
      {msg_available, error_queue_pending, not_vi_mode, fault} <= 4'h0;
      $display("test status byte done");
      cmd(ISR_SRE_WR, 16'h0041);
      fault <= 1'b1;
      repeat (2) @(posedge clock);
      poll(16'h0041);
      cmd(ISR_SRE_WR, 16'h0040);
      poll(16'h0041);
      poll(16'h0001);
      fault <= 1'b0;
      $display("test serial poll done");
      v = rnd() | 16'h0004;
      strobe(v[7:0], 1'b0);
      cmd(ISR_ESE_WR, 16'h00ff);
      repeat (2) @(posedge clock);
      qry(ISR_STB_RD, 3'h0, 16'h0060);
      qry(ISR_ESR_RD, 3'h0, v & 16'h00fd);
      qry(ISR_ESR_RD, 3'h0, 16'h0000);
      strobe(8'h30, 1'b0);
      cmd(ISR_CLS, 16'h0000);
      qry(ISR_ESR_RD, 3'h0, 16'h0000);
      qry(ISR_STB_RD, 3'h0, 16'h0000);
      $display("test events done");
      for (i = 0; i < 4; i++)
      begin
         {transient_active, soft_start_active} <= i[1:0];
         repeat (2) @(posedge clock);
         qry(ISR_OPC_Q, 3'h0, {15'h0, i == 0});
      end
      cmd(ISR_WAI, 16'h0000);
      chk({15'h0, cmd_ready}, 16'h0000);
      fork
         cmd(ISR_OPC, 16'h0000);
         begin
            repeat (8) @(posedge clock);
            chk({15'h0, cmd_ready}, 16'h0000);
            {transient_active, soft_start_active} <= 2'b00;
         end
      join
      qry(ISR_ESR_RD, 3'h0, 16'h0001);
      transient_active <= 1'b1;
      cmd(ISR_OPC, 16'h0000);
      chk({15'h0, cmd_ready}, 16'h0000);
      chk({15'h0, service_request}, 16'h0000);
      transient_active <= 1'b0;
      repeat (2) @(posedge clock);
      chk({15'h0, service_request}, 16'h0001);
      qry(ISR_ESR_RD, 3'h0, 16'h0001);
      $display("test completion done");
      for (i = 0; i < 2; i++)
      begin
         c = rnd() | 16'h0001;
         en = rnd() | 16'h0001;
         if (i == 1) c &= QUES_USED_MASK;
         host.xfer(ISR_GRP_WR, en, i ? G_QUES_ENA : G_OPER_ENA, r);
         qry(ISR_GRP_RD, i ? G_QUES_ENA : G_OPER_ENA, en);
         if (i == 1) ques_cond <= c;
         else oper_cond <= c;
         repeat (3) @(posedge clock);
         qry(ISR_GRP_RD, i ? G_QUES_COND : G_OPER_COND, c);
         {oper_cond, ques_cond} <= 32'h0;
         repeat (2) @(posedge clock);
         qry(ISR_STB_RD, 3'h0, i ? 16'h0048 : 16'h00c0);
         qry(ISR_GRP_RD, i ? G_QUES_EVT : G_OPER_EVT, c);
         qry(ISR_GRP_RD, i ? G_QUES_EVT : G_OPER_EVT, 16'h0000);
      end
      $display("test groups done");
      cmd(ISR_ESE_WR, 16'h0081);
      cmd(ISR_RST, 16'h0000);
      chk({15'h0, reset_busy}, 16'h0001);
      qry(ISR_ESE_RD, 3'h0, 16'h0081);
      chk({15'h0, mode_manual}, 16'h0001);
      $display("test reset command done");
      for (i = 1; i >= 0; i--)
      begin
         cmd(ISR_PSC_WR, 16'(i));
         cmd(ISR_SRE_WR, 16'h0030);
         cmd(ISR_ESE_WR, 16'h0011);
         strobe(8'h00, 1'b1);
         qry(ISR_ESR_RD, 3'h0, 16'h0080);
         qry(ISR_SRE_RD, 3'h0, i ? 16'h0000 : 16'h0030);
         qry(ISR_ESE_RD, 3'h0, i ? 16'h0000 : 16'h0011);
         qry(ISR_PSC_RD, 3'h0, 16'(i));
      end
      $display("test power on done");
      tally_and_finish();
   end
endmodule : isr_status_tb
